// ==== inc/pcr_pkg.sv ====
// package: register map, field layout and carriers of the clock/reset regs
package pcr_pkg;

	// ------------------------------------------------------------
	// register offsets (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_SYNTH_MULT   = 4'h0;
	localparam logic [3:0] IDX_REF_DIV      = 4'h1;
	localparam logic [3:0] IDX_POST_DIV     = 4'h2;
	localparam logic [3:0] IDX_FLAGS        = 4'h3;
	localparam logic [3:0] IDX_IRQ_EN       = 4'h4;
	localparam logic [3:0] IDX_CLK_SEL      = 4'h5;
	localparam logic [3:0] IDX_LOOP_CTL     = 4'h6;
	localparam logic [3:0] IDX_TICK_CTL     = 4'h7;
	localparam logic [3:0] IDX_WDOG_CTL     = 4'h8;
	localparam logic [3:0] IDX_FACT_BYP     = 4'h9;
	localparam logic [3:0] IDX_FACT_CLK     = 4'hA;
	localparam logic [3:0] IDX_WDOG_ARM     = 4'hB;
	localparam logic [3:0] IDX_LAST         = 4'hB;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MULT_W          = 6;
	localparam int POST_DIVIDER_W       = 5;
	localparam int FLG_TICK        = 7;
	localparam int FLG_POWER_ON    = 6;
	localparam int FLG_LOW_VOLT    = 5;
	localparam int FLG_SETTLE_CHG  = 4;
	localparam int FLG_LOCK        = 3;
	localparam int FLG_ILLEGAL     = 2;
	localparam int FLG_SELFCLK_CHG = 1;
	localparam int FLG_SELFCLK     = 0;
	localparam int SEL_LOOP_CHOOSE = 7;

	// ------------------------------------------------------------
	// reset values and write masks
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [7:0] IRQ_EN_MASK  = 8'h92;
	localparam logic [7:0] CLK_SEL_MASK = 8'hCB;
	localparam logic [7:0] WDOG_MASK    = 8'hC7;
	localparam logic [7:0] POST_DIVIDER_MASK = 8'h1F;
	localparam logic [7:0] W1C_MASK     = 8'hF6;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} pcr_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pcr_apb_rsp_t;

	typedef struct packed {
		logic [MULT_W-1:0]    multiplier;
		logic [MULT_W-1:0]    ref_divide;
		logic [POST_DIVIDER_W-1:0] post_divide;
		logic [1:0]           vco_range;
		logic [1:0]           ref_range;
	} pcr_synth_cfg_t;

	typedef struct packed {
		logic power_on;
		logic low_voltage;
		logic illegal_addr;
		logic other;
	} pcr_rst_src_t;

endpackage

// ==== core/pcr_regs.sv ====
// clock and reset generator register block with apb slave
//
// Notes on behaviour
// - reset pin in resets, open-drain out on internal reset
// - divider writes ignored while loop clock chosen
// - multiplier or reference divider write restarts lock detector
// - vco is 2*osc*(mult+1)/(ref_divide_field+1), 6-bit mult
// - post divider divides by 2n, zero passes through
// - tick flag bit 7 set per period, w1c
// - power-on flag bit 6, survives system resets
// - low-voltage flag bit 5, survives system resets
// - illegal flag bit 2, cleared by por/lvr
// - lock-change flag bit 4 on lock toggle
// - lock status bit 3, zero in self-clock
// - self-clock-change flag bit 1 on toggle
// - self-clock status bit 0 read-only
// - factory test registers read zero
// - registers decoded at base plus offset 0..B
// - enables 7,4,1 gate flag interrupt requests
// - loop clock choose cannot be set while unlocked; a clear is taken
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module pcr_regs
	import pcr_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
	input  wire logic           mclk,
	input  wire logic           rst_b,
	input  wire pcr_apb_req_t   apb_req,
	output pcr_apb_rsp_t        apb_rsp,
	input  wire logic           reset_pin_in,
	output logic                reset_pin_out,
	output logic                reset_pin_oe,
	input  wire pcr_rst_src_t   rst_src,
	input  wire logic           tick_event,
	input  wire logic           lock_detect_in,
	input  wire logic           selfclock_in,
	output pcr_synth_cfg_t      synth_cfg,
	output logic                lock_detect_restart,
	output logic                loop_clock_choose,
	output logic [7:0]          loop_control,
	output logic [7:0]          tick_rate_control,
	output logic [7:0]          watchdog_control,
	output logic                watchdog_arm_strobe,
	output logic [7:0]          watchdog_arm_data,
	output logic                irq_tick,
	output logic                irq_settle_change,
	output logic                irq_selfclock_change
);

	// ------------------------------------------------------------
	// pin and status synchronisers
	// ------------------------------------------------------------
	// three stages; a change counts when stages two and three agree
	logic [2:0] pin_sync_reg;
	logic [2:0] lock_sync_reg;
	logic [2:0] scm_sync_reg;
	logic       pin_low_reg;
	logic       lock_raw_reg;
	logic       scm_reg;
	logic       scm_next;

	// status, lock view and change flag all move at one edge
	assign scm_next = (scm_sync_reg[2] == scm_sync_reg[1]) ?
	                  scm_sync_reg[2] : scm_reg;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_sync_reg  <= 3'h7;
			lock_sync_reg <= 3'h0;
			scm_sync_reg  <= 3'h0;
		end else begin
			pin_sync_reg  <= {pin_sync_reg[1:0], reset_pin_in};
			lock_sync_reg <= {lock_sync_reg[1:0], lock_detect_in};
			scm_sync_reg  <= {scm_sync_reg[1:0], selfclock_in};
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_low_reg  <= 1'b0;
			lock_raw_reg <= 1'b0;
			scm_reg      <= 1'b0;
		end else begin
			if (pin_sync_reg[2] == pin_sync_reg[1])
				pin_low_reg <= ~pin_sync_reg[2];
			if (lock_sync_reg[2] == lock_sync_reg[1])
				lock_raw_reg <= lock_sync_reg[2];
			scm_reg <= scm_next;
		end
	end

	// ------------------------------------------------------------
	// system reset: pin drive and register reset
	// ------------------------------------------------------------
	// rst_b is the asynchronous por of this block; the pin and the
	// internal sources reset the clock settings synchronously.
	logic any_internal_rst;
	logic sys_rst;
	logic por_lvr;

	assign any_internal_rst = rst_src.power_on | rst_src.low_voltage |
	                          rst_src.illegal_addr | rst_src.other;
	assign sys_rst          = any_internal_rst | pin_low_reg;
	assign por_lvr          = rst_src.power_on | rst_src.low_voltage;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reset_pin_out <= 1'b0;
			reset_pin_oe  <= 1'b1;
		end else begin
			reset_pin_out <= 1'b0;
			reset_pin_oe  <= any_internal_rst;
		end
	end

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic       in_window;
	logic [3:0] idx;
	logic       wr_acc;
	logic       rd_acc;
	logic [31:0] rel_addr;
	logic [7:0] wbyte;

	assign rel_addr  = apb_req.paddr - BASE_ADDR;
	assign idx       = rel_addr[5:2];
	assign in_window = (rel_addr[31:6] == 26'h0) &&
	                   (rel_addr[1:0] == 2'h0) &&
	                   (idx <= IDX_LAST);
	assign wr_acc    = apb_req.psel && apb_req.penable && apb_req.pwrite &&
	                   !apb_rsp.pready;
	assign rd_acc    = apb_req.psel && apb_req.penable && !apb_req.pwrite &&
	                   !apb_rsp.pready;
	assign wbyte     = apb_req.pwdata[7:0];

	function automatic logic wr_hit(input logic [3:0] i);
		wr_hit = wr_acc && in_window && (idx == i);
	endfunction

	// ------------------------------------------------------------
	// synthesizer settings
	// ------------------------------------------------------------
	logic [7:0] synth_mult_reg;
	logic [7:0] ref_div_reg;
	logic [7:0] post_div_reg;
	logic       cfg_open;

	assign cfg_open = !loop_clock_choose;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			synth_mult_reg <= RST_BYTE;
			ref_div_reg    <= RST_BYTE;
			post_div_reg   <= RST_BYTE;
		end else if (sys_rst) begin
			synth_mult_reg <= RST_BYTE;
			ref_div_reg    <= RST_BYTE;
			post_div_reg   <= RST_BYTE;
		end else if (cfg_open) begin
			if (wr_hit(IDX_SYNTH_MULT))
				synth_mult_reg <= wbyte;
			if (wr_hit(IDX_REF_DIV))
				ref_div_reg <= wbyte;
			if (wr_hit(IDX_POST_DIV))
				post_div_reg <= wbyte & POST_DIVIDER_MASK;
		end
	end

	// loop core takes the fields and forms vco and post division
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			synth_cfg <= '0;
		end else begin
			synth_cfg.multiplier  <= synth_mult_reg[MULT_W-1:0];
			synth_cfg.ref_divide  <= ref_div_reg[MULT_W-1:0];
			synth_cfg.post_divide <= post_div_reg[POST_DIVIDER_W-1:0];
			// range codes are copied as written; software owns them
			synth_cfg.vco_range   <= synth_mult_reg[7:6];
			synth_cfg.ref_range   <= ref_div_reg[7:6];
		end
	end

	// restart pulse; lock view is held low until the detector
	// has had a fresh cycle of input after the restart
	logic restart_hold_reg;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lock_detect_restart <= 1'b0;
			restart_hold_reg    <= 1'b0;
		end else begin
			lock_detect_restart <= cfg_open && !sys_rst &&
			    (wr_hit(IDX_SYNTH_MULT) || wr_hit(IDX_REF_DIV));
			restart_hold_reg <= lock_detect_restart;
		end
	end

	// ------------------------------------------------------------
	// lock status and change detection
	// ------------------------------------------------------------
	logic lock_reg;
	logic lock_next;

	always_comb begin
		lock_next = lock_raw_reg;
		if (scm_next || lock_detect_restart || restart_hold_reg)
			lock_next = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lock_reg     <= 1'b0;
		end else begin
			lock_reg     <= lock_next;
		end
	end

	// ------------------------------------------------------------
	// flags register
	// ------------------------------------------------------------
	logic       tick_flag;
	logic       power_on_flag;
	logic       low_voltage_flag;
	logic       settle_change_flag;
	logic       illegal_address_flag;
	logic       selfclock_change_flag;
	logic [7:0] flag_clr;

	assign flag_clr = wr_hit(IDX_FLAGS) ? (wbyte & W1C_MASK) : 8'h00;

	// set term wins over a same-cycle clear
	function automatic logic w1c(input logic cur, input logic set,
	                             input logic clr);
		w1c = set | (cur & ~clr);
	endfunction

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			power_on_flag    <= 1'b1;
			low_voltage_flag <= 1'b0;
			illegal_address_flag <= 1'b0;
		end else begin
			power_on_flag <= w1c(power_on_flag, rst_src.power_on,
			                     flag_clr[FLG_POWER_ON]);
			low_voltage_flag <= w1c(low_voltage_flag, rst_src.low_voltage,
			                        flag_clr[FLG_LOW_VOLT]);
			if (por_lvr)
				illegal_address_flag <= 1'b0;
			else
				illegal_address_flag <= w1c(illegal_address_flag,
				    rst_src.illegal_addr, flag_clr[FLG_ILLEGAL]);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tick_flag             <= 1'b0;
			settle_change_flag    <= 1'b0;
			selfclock_change_flag <= 1'b0;
		end else if (sys_rst) begin
			tick_flag             <= 1'b0;
			settle_change_flag    <= 1'b0;
			selfclock_change_flag <= 1'b0;
		end else begin
			tick_flag <= w1c(tick_flag, tick_event,
			                 flag_clr[FLG_TICK]);
			settle_change_flag <= w1c(settle_change_flag,
			    lock_next ^ lock_reg, flag_clr[FLG_SETTLE_CHG]);
			selfclock_change_flag <= w1c(selfclock_change_flag,
			    scm_next ^ scm_reg, flag_clr[FLG_SELFCLK_CHG]);
		end
	end

	// ------------------------------------------------------------
	// enables, clock select and plain control registers
	// ------------------------------------------------------------
	logic [7:0] irq_en_reg;
	logic [7:0] clk_sel_reg;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_en_reg        <= RST_BYTE;
			loop_control      <= RST_BYTE;
			tick_rate_control <= RST_BYTE;
			watchdog_control  <= RST_BYTE;
		end else if (sys_rst) begin
			irq_en_reg        <= RST_BYTE;
			loop_control      <= RST_BYTE;
			tick_rate_control <= RST_BYTE;
			watchdog_control  <= RST_BYTE;
		end else begin
			if (wr_hit(IDX_IRQ_EN))
				irq_en_reg <= wbyte & IRQ_EN_MASK;
			if (wr_hit(IDX_LOOP_CTL))
				loop_control <= wbyte;
			if (wr_hit(IDX_TICK_CTL))
				tick_rate_control <= wbyte;
			if (wr_hit(IDX_WDOG_CTL))
				watchdog_control <= wbyte & WDOG_MASK;
		end
	end

	// choose bit drops on self-clock entry so the system clock
	// never stays on a loop that lost its reference
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clk_sel_reg <= RST_BYTE;
		end else if (sys_rst) begin
			clk_sel_reg <= RST_BYTE;
		end else begin
			if (wr_hit(IDX_CLK_SEL)) begin
				clk_sel_reg <= wbyte & CLK_SEL_MASK;
				if (!lock_reg && !clk_sel_reg[SEL_LOOP_CHOOSE])
					clk_sel_reg[SEL_LOOP_CHOOSE] <= 1'b0;
				else if (!lock_reg)
					clk_sel_reg[SEL_LOOP_CHOOSE] <=
					    wbyte[SEL_LOOP_CHOOSE];
			end
			if (scm_reg)
				clk_sel_reg[SEL_LOOP_CHOOSE] <= 1'b0;
		end
	end

	assign loop_clock_choose = clk_sel_reg[SEL_LOOP_CHOOSE];

	// ------------------------------------------------------------
	// watchdog arm strobe
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_arm_strobe <= 1'b0;
			watchdog_arm_data   <= RST_BYTE;
		end else begin
			watchdog_arm_strobe <= wr_hit(IDX_WDOG_ARM);
			if (wr_hit(IDX_WDOG_ARM))
				watchdog_arm_data <= wbyte;
		end
	end

	// ------------------------------------------------------------
	// interrupt requests
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_tick             <= 1'b0;
			irq_settle_change    <= 1'b0;
			irq_selfclock_change <= 1'b0;
		end else begin
			irq_tick <= tick_flag & irq_en_reg[FLG_TICK];
			irq_settle_change <= settle_change_flag &
			                     irq_en_reg[FLG_SETTLE_CHG];
			irq_selfclock_change <= selfclock_change_flag &
			                        irq_en_reg[FLG_SELFCLK_CHG];
		end
	end

	// ------------------------------------------------------------
	// read mux and apb answer
	// ------------------------------------------------------------
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			IDX_SYNTH_MULT: rd_byte = synth_mult_reg;
			IDX_REF_DIV:    rd_byte = ref_div_reg;
			IDX_POST_DIV:   rd_byte = post_div_reg;
			IDX_FLAGS:      rd_byte = {tick_flag, power_on_flag,
			                           low_voltage_flag, settle_change_flag,
			                           lock_reg, illegal_address_flag,
			                           selfclock_change_flag, scm_reg};
			IDX_IRQ_EN:     rd_byte = irq_en_reg;
			IDX_CLK_SEL:    rd_byte = clk_sel_reg;
			IDX_LOOP_CTL:   rd_byte = loop_control;
			IDX_TICK_CTL:   rd_byte = tick_rate_control;
			IDX_WDOG_CTL:   rd_byte = watchdog_control;
			default:        rd_byte = 8'h00;
		endcase
	end

	// one wait state: answer one edge after the access phase opens
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready  <= wr_acc || rd_acc;
			apb_rsp.pslverr <= (wr_acc || rd_acc) && !in_window;
			apb_rsp.prdata  <= (rd_acc && in_window) ?
			                   {24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

endmodule

// ==== tb/pcr_regs_properties.sv ====
// checker: port-level properties of the clock/reset register block
`timescale 1ns/100ps
module pcr_regs_properties
	import pcr_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
	input wire logic           mclk,
	input wire logic           rst_b,
	input wire pcr_apb_req_t   apb_req,
	input wire pcr_apb_rsp_t   apb_rsp,
	input wire pcr_rst_src_t   rst_src,
	input wire logic           reset_pin_out,
	input wire logic           reset_pin_oe,
	input wire pcr_synth_cfg_t synth_cfg,
	input wire logic           lock_detect_restart,
	input wire logic           loop_clock_choose
);
	wire       tk    = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
	wire [5:0] wd_lo = apb_req.pwdata[5:0];
	wire [1:0] wd_hi = apb_req.pwdata[7:6];
	wire [4:0] wd_pd = apb_req.pwdata[4:0];

	function automatic logic hit(input logic [3:0] i);
		return apb_req.paddr == BASE_ADDR + {26'h0, i, 2'b00};
	endfunction

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_wr(logic [3:0] i);
		tk && apb_req.pwrite && hit(i) && !(|rst_src);
	endsequence
	sequence s_rd(logic [3:0] i);
		tk && !apb_req.pwrite && hit(i);
	endsequence

	property p_ready;
		tk |=> apb_rsp.pready;
	endproperty
	property p_oe;
		(|rst_src) |=> reset_pin_oe;
	endproperty
	property p_odrain;
		reset_pin_oe |-> !reset_pin_out;
	endproperty
	property p_restart;
		(s_wr(IDX_SYNTH_MULT) or s_wr(IDX_REF_DIV)) ##0 !loop_clock_choose
			|-> ##[1:2] lock_detect_restart;
	endproperty
	property p_hold;
		(s_wr(IDX_SYNTH_MULT) or s_wr(IDX_REF_DIV) or s_wr(IDX_POST_DIV))
			##0 loop_clock_choose
			|=> ($stable(synth_cfg) && !lock_detect_restart) [*2];
	endproperty
	property p_mult;
		s_wr(IDX_SYNTH_MULT) ##0 !loop_clock_choose
			|=> ##1 synth_cfg.multiplier == $past(wd_lo, 2)
			&& synth_cfg.vco_range == $past(wd_hi, 2);
	endproperty
	property p_ref;
		s_wr(IDX_REF_DIV) ##0 !loop_clock_choose
			|=> ##1 synth_cfg.ref_divide == $past(wd_lo, 2)
			&& synth_cfg.ref_range == $past(wd_hi, 2);
	endproperty
	property p_post;
		s_wr(IDX_POST_DIV) ##0 !loop_clock_choose
			|=> ##1 synth_cfg.post_divide == $past(wd_pd, 2);
	endproperty
	property p_fact;
		(s_rd(IDX_FACT_BYP) or s_rd(IDX_FACT_CLK))
			|=> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr;
	endproperty

	a_ready: assert property (p_ready) else $error("no pready");
	a_oe: assert property (p_oe) else $error("pin not pulled");
	a_odrain: assert property (p_odrain) else $error("pin high");
	a_restart: assert property (p_restart) else $error("no restart");
	a_hold: assert property (p_hold) else $error("cfg moved");
	a_mult: assert property (p_mult) else $error("mult bad");
	a_ref: assert property (p_ref) else $error("ref_divide_field bad");
	a_post: assert property (p_post) else $error("post bad");
	a_fact: assert property (p_fact) else $error("test reg");
endmodule

bind pcr_regs pcr_regs_properties #(.BASE_ADDR(BASE_ADDR)) pcr_props_i (
	.mclk(mclk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.rst_src(rst_src), .reset_pin_out(reset_pin_out),
	.reset_pin_oe(reset_pin_oe), .synth_cfg(synth_cfg),
	.lock_detect_restart(lock_detect_restart),
	.loop_clock_choose(loop_clock_choose));

// ==== tb/pcr_pll_model.sv ====
// model: analog loop lock detector seen from the register block
`timescale 1ns/100ps
module pcr_pll_model #(
	parameter int LOCK_DLY = 6
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic lock_detect_restart,
	input wire logic want_lock,
	output logic     lock_detect_in
);
	int cnt;

	// lock only after a settling time, never straight after a restart
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			lock_detect_in <= 1'b0;
		end else if (lock_detect_restart || !want_lock) begin
			cnt <= 0;
			lock_detect_in <= 1'b0;
		end else if (cnt < LOCK_DLY) begin
			cnt <= cnt + 1;
		end else begin
			lock_detect_in <= 1'b1;
		end
	end
endmodule

// ==== tb/tb.sv ====
// testbench: registers, flags and resets of the clock/reset block
`timescale 1ns/100ps
module tb
	import pcr_pkg::*;
;
	localparam logic [31:0] BASE = 32'h0000_0400;
	logic           mclk, rst_b, ext_rst_b, tick, want_lock, selfclock_status;
	logic           pin_b, pin_out, pin_oe, restart, choose, lock_in;
	logic           irq_t, irq_l, irq_s, er, arm_s;
	logic [7:0]     lc, trc, wc, arm_d;
	logic [31:0]    rv;
	pcr_apb_req_t   rq;
	pcr_apb_rsp_t   rsp;
	pcr_rst_src_t   src;
	pcr_synth_cfg_t cfg;
	int             num_errors = 0;
	int             n_tests = 0;
	int             cyc = 0;
	int             n_arm = 0;

	// open-drain line with pull-up
	assign pin_b = ext_rst_b & ~(pin_oe & ~pin_out);

	pcr_regs #(.BASE_ADDR(BASE)) pcr_regs_i (.mclk(mclk), .rst_b(rst_b),
		.apb_req(rq), .apb_rsp(rsp), .reset_pin_in(pin_b),
		.reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .rst_src(src),
		.tick_event(tick), .lock_detect_in(lock_in), .selfclock_in(selfclock_status),
		.synth_cfg(cfg), .lock_detect_restart(restart),
		.loop_clock_choose(choose), .loop_control(lc),
		.tick_rate_control(trc), .watchdog_control(wc),
		.watchdog_arm_strobe(arm_s), .watchdog_arm_data(arm_d),
		.irq_tick(irq_t),
		.irq_settle_change(irq_l), .irq_selfclock_change(irq_s));
	pcr_pll_model pcr_pll_model_i (.mclk(mclk), .rst_b(rst_b),
		.lock_detect_restart(restart), .want_lock(want_lock),
		.lock_detect_in(lock_in));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			stop_test;
		end
	end

	// arm strobe stands one cycle, so count it where it happens
	always @(posedge mclk) begin
		if (arm_s)
			n_arm <= n_arm + 1;
	end

	task stop_test;
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask

	// ----------------------------------------
	// apb master
	// ----------------------------------------
	task apb(input logic [3:0] i, input logic w, input logic [7:0] d);
		int k;
		@(posedge mclk);
		rq <= '{BASE + {26'h0, i, 2'b00}, 1'b1, 1'b0, w, {24'h0, d}};
		@(posedge mclk) rq.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (rsp.pready !== 1'b1);
		rv = rsp.prdata;
		er = rsp.pslverr;
		rq.psel <= 1'b0;
		rq.penable <= 1'b0;
		chk("access edges", 32'h2, k);
	endtask

	task rdc(input string n, input logic [3:0] i, input logic [31:0] e);
		apb(i, 1'b0, 8'h00);
		chk(n, e, rv);
	endtask

	task wrd(input logic [3:0] i, input logic [7:0] d, input logic [31:0] e);
		apb(i, 1'b1, d);
		rdc("readback", i, e);
	endtask

	// polls the flags until bit b shows v; at most 30 reads
	task poll(input int b, input logic v);
		int k;
		k = 0;
		do begin
			apb(IDX_FLAGS, 1'b0, 8'h00);
			k++;
		end while (rv[b] !== v && k < 30);
	endtask

	task pulse(input pcr_rst_src_t s);
		@(posedge mclk) src <= s;
		@(posedge mclk);
		@(negedge mclk) chk("pin oe", 32'h1, pin_oe);
		@(posedge mclk) src <= '0;
		repeat (8) @(posedge mclk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		for (int i = 0; i < 12; i++)
			rdc("reset val", i[3:0], i == 3 ? 32'h40 : 32'h0);
		wrd(IDX_FACT_CLK, 8'hFF, 32'h0);
		apb(4'hC, 1'b0, 8'h00);
		chk("unmapped", 32'h1, er);
	endtask

	task t_sysrst;
		pulse(4'h1);
		rdc("por kept", IDX_FLAGS, 32'h40);
		wrd(IDX_FLAGS, 8'h00, 32'h40);
		wrd(IDX_FLAGS, 8'h40, 32'h00);
		pulse(4'h2);
		rdc("ila set", IDX_FLAGS, 32'h04);
		pulse(4'h1);
		rdc("ila kept", IDX_FLAGS, 32'h04);
		pulse(4'h4);
		rdc("lvr set", IDX_FLAGS, 32'h20);
		wrd(IDX_FLAGS, 8'h00, 32'h20);
		wrd(IDX_FLAGS, 8'h20, 32'h00);
		wrd(IDX_IRQ_EN, 8'h92, 32'h92);
		@(posedge mclk) ext_rst_b <= 1'b0;
		repeat (6) @(posedge mclk);
		ext_rst_b <= 1'b1;
		repeat (12) @(posedge mclk);
		rdc("pin reset", IDX_IRQ_EN, 32'h0);
	endtask

	task t_cfg;
		wrd(IDX_SYNTH_MULT, 8'hC5, 32'hC5);
		chk("mult", 32'h05, cfg.multiplier);
		chk("vco", 32'h3, cfg.vco_range);
		wrd(IDX_REF_DIV, 8'h83, 32'h83);
		chk("ref div", 32'h03, cfg.ref_divide);
		chk("ref rng", 32'h2, cfg.ref_range);
		wrd(IDX_POST_DIV, 8'hFF, 32'h1F);
		chk("post", 32'h1F, cfg.post_divide);
		wrd(IDX_POST_DIV, 8'h00, 32'h00);
		wrd(IDX_LOOP_CTL, 8'hA5, 32'hA5);
		chk("loop ctl", 32'hA5, lc);
		wrd(IDX_TICK_CTL, 8'h5A, 32'h5A);
		chk("tick ctl", 32'h5A, trc);
		wrd(IDX_WDOG_CTL, 8'hFF, {24'h0, WDOG_MASK});
		chk("wdog ctl", {24'h0, WDOG_MASK}, wc);
		wrd(IDX_WDOG_ARM, 8'h3C, 32'h0);
		chk("arm data", 32'h3C, arm_d);
		chk("arm count", 32'h1, n_arm);
		for (int v = 0; v < 4; v++) begin
			if (v != 2)
				wrd(IDX_SYNTH_MULT, {v[1:0], 6'h2A}, {24'h0, v[1:0], 6'h2A});
			wrd(IDX_REF_DIV, {v[1:0], 6'h3F}, {24'h0, v[1:0], 6'h3F});
		end
	endtask

	task t_irq;
		wrd(IDX_IRQ_EN, 8'hFF, 32'h92);
		@(posedge mclk) tick <= 1'b1;
		@(posedge mclk) tick <= 1'b0;
		rdc("tick", IDX_FLAGS, 32'h80);
		chk("irq tick", 32'h1, irq_t);
		wrd(IDX_IRQ_EN, 8'h12, 32'h12);
		chk("irq mask", 32'h0, irq_t);
		wrd(IDX_FLAGS, 8'h7F, 32'h80);
		wrd(IDX_FLAGS, 8'h80, 32'h00);
		@(posedge mclk) selfclock_status <= 1'b1;
		poll(0, 1'b1);
		chk("scm on", 32'h03, rv);
		chk("irq scm", 32'h1, irq_s);
		apb(IDX_FLAGS, 1'b1, 8'h02);
		@(posedge mclk) selfclock_status <= 1'b0;
		poll(0, 1'b0);
		chk("scm off", 32'h02, rv);
		wrd(IDX_FLAGS, 8'hFF, 32'h00);
	endtask

	task t_lock;
		wrd(IDX_CLK_SEL, 8'h80, 32'h00);
		@(posedge mclk) want_lock <= 1'b1;
		poll(3, 1'b1);
		chk("lock", 32'h18, rv);
		chk("irq lock", 32'h1, irq_l);
		wrd(IDX_CLK_SEL, 8'h80, 32'h80);
		chk("choose", 32'h1, choose);
		for (int i = 0; i < 3; i++)
			wrd(i[3:0], 8'h15, i == 0 ? 32'hEA : i == 1 ? 32'hFF : 32'h0);
		wrd(IDX_FLAGS, 8'h10, 32'h08);
		@(posedge mclk) selfclock_status <= 1'b1;
		poll(0, 1'b1);
		chk("lock in scm", 32'h13, rv);
	endtask

	initial begin
		rq = '0;
		src = '0;
		ext_rst_b = 1'b1;
		tick = 1'b0;
		want_lock = 1'b0;
		selfclock_status = 1'b0;
		rst_b = 1'b0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset;
		t_sysrst;
		t_cfg;
		t_irq;
		t_lock;
		stop_test;
	end
endmodule
